// [verilog/irb_bezel_scan.sv]
// Panel scan controller: sensor RAM, host command and data port, emitter latch
`timescale 1ns/10ps
`default_nettype none
module irb_bezel_scan
  import irb_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic [21:0] row_beam,
  input wire logic [10:0] col_beam,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [1:0] host_sel,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  output logic host_rvalid,
  output logic emitter_disable_n,
  output logic panel_irq_request,
  input wire logic [7:0] other_irq,
  output logic [7:0] irq_request_reg
);

  function automatic logic [7:0] byte_of(input logic [63:0] vec, input logic [2:0] idx);
    byte_of = vec[{idx, 3'h0} +: 8];
  endfunction : byte_of

  logic [63:0] ram_vec;
  logic [63:0] next_ram_vec;
  logic [10:0] col_bits;
  logic [21:0] row_bits;
  logic [2:0] rd_ptr;
  logic [7:0] rd_byte;
  logic [7:0] irq_lines;
  logic cmd_wr;
  logic emit_wr;
  logic data_rd;
  logic read_cmd;
  logic clear_cmd;
  logic sensor_change;

  assign cmd_wr = host_wr && (host_sel == SEL_COMMAND);
  assign emit_wr = host_wr && (host_sel == SEL_EMITTER);
  assign data_rd = host_rd && (host_sel == SEL_DATA);
  assign read_cmd = cmd_wr && (host_wdata == CMD_READ_RAM);
  assign clear_cmd = cmd_wr && (host_wdata == CMD_CLEAR_IRQ);

  // Dark emitters mean no beam at all, so force ones rather than trust stray light
  genvar gi;
  generate
    for (gi = 0; gi < COL_COUNT; gi++) begin : g_col
      assign col_bits[gi] = !emitter_disable_n || !col_beam[gi];
    end
    for (gi = 0; gi < ROW_COUNT; gi++) begin : g_row
      assign row_bits[gi] = !emitter_disable_n || !row_beam[gi];
    end
  endgenerate

  assign next_ram_vec = {29'h0, col_bits, 2'h0, row_bits};
  assign sensor_change = (next_ram_vec != ram_vec);
  assign rd_byte = byte_of(ram_vec, rd_ptr);

  // Emitter latch; other codes are ignored
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      emitter_disable_n <= EMIT_RST;
    end else if (emit_wr && (host_wdata == EMIT_OFF)) begin
      emitter_disable_n <= 1'b0;
    end else if (emit_wr && (host_wdata == EMIT_ON)) begin
      emitter_disable_n <= 1'b1;
    end
  end

  // Sensor RAM refreshed every clock; inputs assumed already debounced
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ram_vec <= RAM_RST;
    end else begin
      ram_vec <= next_ram_vec;
    end
  end

  // Sticky interrupt; a change in the clear cycle wins
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      panel_irq_request <= 1'b0;
    end else if (sensor_change) begin
      panel_irq_request <= 1'b1;
    end else if (clear_cmd) begin
      panel_irq_request <= 1'b0;
    end
  end

  // Read pointer wraps after byte 7 so extra reads restart the RAM
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rd_ptr <= PTR_RST;
    end else if (read_cmd) begin
      rd_ptr <= PTR_RST;
    end else if (data_rd) begin
      rd_ptr <= rd_ptr + 3'h1;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      host_rdata <= 8'h00;
      host_rvalid <= 1'b0;
    end else begin
      host_rvalid <= host_rd;
      if (data_rd) begin
        host_rdata <= rd_byte;
      end else if (host_rd && (host_sel == SEL_EMITTER)) begin
        host_rdata <= {7'h0, emitter_disable_n};
      end else if (host_rd) begin
        host_rdata <= 8'h00;
      end
    end
  end

  always_comb begin
    irq_lines = other_irq;
    irq_lines[PANEL_IRQ_LINE] = panel_irq_request;
  end

  irb_irq_request_reg u_master_irq_controller (
    .mclk(mclk),
    .reset(reset),
    .irq_in(irq_lines),
    .request_reg(irq_request_reg)
  );

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  AST_EMIT_OFF: assert property (
    emit_wr && (host_wdata == EMIT_OFF) |=> !emitter_disable_n)
    else $error("Emitters not disabled by 0x00");

  AST_EMIT_ON: assert property (
    emit_wr && (host_wdata == EMIT_ON) |=> emitter_disable_n)
    else $error("Emitters not enabled by 0x01");

  AST_READ_REWIND: assert property (
    read_cmd ##1 data_rd |=> host_rvalid && (host_rdata == $past(ram_vec[7:0])))
    else $error("First read after 0x60 is not RAM byte 0");

  AST_READ_STEP: assert property (
    data_rd && !read_cmd |=> (rd_ptr == $past(rd_ptr) + 3'h1) &&
      (host_rdata == $past(rd_byte)))
    else $error("Data read did not step through the RAM");

  AST_CLEAR: assert property (
    clear_cmd && !sensor_change |=> !panel_irq_request)
    else $error("Clear command left the interrupt pending");

  AST_IRQ_LINE: assert property (
    ##1 irq_request_reg[PANEL_IRQ_LINE] == $past(panel_irq_request))
    else $error("Request register bit 4 does not follow the panel interrupt");

  AST_COL_POLARITY: assert property (
    !$past(reset) && $past(emitter_disable_n) |->
      ram_vec[COL_BASE +: COL_COUNT] == ~$past(col_beam))
    else $error("Column bit does not mirror its beam");

  AST_ROW_POLARITY: assert property (
    !$past(reset) && $past(emitter_disable_n) |->
      ram_vec[ROW_COUNT-1:0] == ~$past(row_beam))
    else $error("Row bit does not mirror its beam");

  AST_DARK_COLS: assert property (
    !emitter_disable_n ##1 !emitter_disable_n |->
      (ram_vec[COL_BASE +: COL_COUNT] == COL_ALL_DARK) &&
      (ram_vec[ROW_COUNT-1:0] == ROW_ALL_DARK))
    else $error("Sensor bits not all 1 with emitters off");

  AST_BEAM_LOSS: assert property (
    emitter_disable_n && !col_beam[0] ##1 emitter_disable_n |-> ram_vec[COL_BASE])
    else $error("Lost beam did not read as 1");

  AST_CHANGE_IRQ: assert property (
    ram_vec != $past(ram_vec) |-> panel_irq_request)
    else $error("Sensor change did not raise the interrupt");

  AST_IRQ_HOLD: assert property (
    panel_irq_request && !clear_cmd |=> panel_irq_request)
    else $error("Interrupt dropped without a clear command");

  AST_RVALID_SET: assert property (
    host_rd |=> host_rvalid)
    else $error("Read strobe not answered next cycle");

  AST_RVALID_DROP: assert property (
    !host_rd |=> !host_rvalid)
    else $error("Read answer without a read strobe");

  AST_PTR_WRAP: assert property (
    data_rd && (rd_ptr == PTR_LAST) |=> (rd_ptr == PTR_RST))
    else $error("Read pointer did not wrap after byte 7");

  AST_PTR_HOLD: assert property (
    !data_rd && !read_cmd |=> $stable(rd_ptr))
    else $error("Read pointer moved without a data read");

  AST_EMIT_HOLD: assert property (
    !(emit_wr && ((host_wdata == EMIT_OFF) || (host_wdata == EMIT_ON))) |=>
      $stable(emitter_disable_n))
    else $error("Emitter line moved without a valid write");

  AST_IRQ_CAUSE: assert property (
    $rose(panel_irq_request) |-> (ram_vec != $past(ram_vec)))
    else $error("Interrupt raised without a sensor change");

  AST_READ_HOLD: assert property (
    !host_rd |=> $stable(host_rdata))
    else $error("Read data changed without a read");

  AST_OTHER_LINES: assert property (
    !$past(reset) |-> (irq_request_reg[3:0] == $past(other_irq[3:0])) &&
      (irq_request_reg[7:5] == $past(other_irq[7:5])))
    else $error("Other request lines not captured");

  COV_EMIT_OFF: cover property (emit_wr && (host_wdata == EMIT_OFF) ##1 panel_irq_request);
  COV_READ_EIGHT: cover property (read_cmd ##1 data_rd [*8]);
  COV_CLEAR: cover property (panel_irq_request ##1 clear_cmd ##1 !panel_irq_request);
  COV_SET_WINS: cover property (clear_cmd && sensor_change);
  COV_WRAP: cover property (data_rd && (rd_ptr == PTR_LAST) ##1 data_rd);

endmodule : irb_bezel_scan
`default_nettype wire

// [include/irb_pkg.sv]
// Constants and host port map of the infrared bezel scan block
package irb_pkg;
  localparam int ROW_COUNT = 22;
  localparam int COL_COUNT = 11;
  localparam int RAM_BYTES = 8;
  localparam int COL_BASE = 24;
  localparam logic [1:0] SEL_COMMAND = 2'h0;
  localparam logic [1:0] SEL_DATA = 2'h1;
  localparam logic [1:0] SEL_EMITTER = 2'h2;
  localparam logic [7:0] CMD_READ_RAM = 8'h60;
  localparam logic [7:0] CMD_CLEAR_IRQ = 8'he0;
  localparam logic [7:0] EMIT_OFF = 8'h00;
  localparam logic [7:0] EMIT_ON = 8'h01;
  localparam int PANEL_IRQ_LINE = 4;
  localparam logic EMIT_RST = 1'b1;
  localparam logic [63:0] RAM_RST = 64'h0000_0007_ff3f_ffff;
  localparam logic [2:0] PTR_RST = 3'h0;
  localparam logic [2:0] PTR_LAST = 3'h7;
  localparam logic [7:0] IRQ_REG_RST = 8'h00;
  localparam logic [10:0] COL_ALL_DARK = 11'h7ff;
  localparam logic [21:0] ROW_ALL_DARK = 22'h3fffff;
endpackage : irb_pkg

// [verilog/irb_irq_request_reg.sv]
// Request register of the master interrupt controller
`timescale 1ns/10ps
`default_nettype none
module irb_irq_request_reg
  import irb_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic [7:0] irq_in,
  output logic [7:0] request_reg
);
  // Captures the request lines every clock, one cycle of latency
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      request_reg <= IRQ_REG_RST;
    end else begin
      request_reg <= irq_in;
    end
  end
endmodule : irb_irq_request_reg
`default_nettype wire

// [tb/irb_beam_array.sv]
// Beam array model: lit pairs unless emitters are off or a pair is blocked
`timescale 1ns/10ps
`default_nettype none
module irb_beam_array (
  input wire logic emitter_disable_n,
  input wire logic [21:0] row_block,
  input wire logic [10:0] col_block,
  output logic [21:0] row_beam,
  output logic [10:0] col_beam
);
  // No stray light: with emitters off every receptor is dark
  assign row_beam = emitter_disable_n ? ~row_block : 22'h000000;
  assign col_beam = emitter_disable_n ? ~col_block : 11'h000;
endmodule : irb_beam_array
`default_nettype wire

// [tb/irb_bezel_scan_tb_top.sv]
// Self-checking bench of the bezel scan block
`timescale 1ns/10ps
`default_nettype none
module irb_bezel_scan_tb_top;
  import irb_pkg::*;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic host_wr = 1'b0;
  logic host_rd = 1'b0;
  logic [1:0] host_sel = 2'h0;
  logic [7:0] host_wdata = 8'h00;
  logic [7:0] other_irq = 8'h00;
  logic [21:0] row_block = 22'h000000;
  logic [10:0] col_block = 11'h000;
  logic [7:0] host_rdata, irq_request_reg, got;
  logic host_rvalid, emitter_disable_n, panel_irq_request, emit_on;
  logic [21:0] row_beam;
  logic [10:0] col_beam;
  logic [15:0] rnd = 16'hed73;
  logic [63:0] exp_ram;
  logic [7:0] exp_q[$];
  int n_fail = 0;
  int compares = 0;
  int cyc = 0;
  always #50 mclk = ~mclk;
  irb_beam_array arr_u (.emitter_disable_n, .row_block, .col_block, .row_beam, .col_beam);
  irb_bezel_scan dut_u (.mclk, .reset, .row_beam, .col_beam, .host_wr, .host_rd, .host_sel,
    .host_wdata, .host_rdata, .host_rvalid, .emitter_disable_n, .panel_irq_request,
    .other_irq, .irq_request_reg);
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr
  task automatic give_verdict();
    if (n_fail == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    compares++;
    if (seen !== want) begin
      n_fail++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check
  task automatic put(input logic [1:0] sel, input logic [7:0] d);
    @(posedge mclk);
    host_wr <= 1'b1;
    host_sel <= sel;
    host_wdata <= d;
    @(posedge mclk);
    host_wr <= 1'b0;
  endtask : put
  task automatic get(input logic [1:0] sel);
    @(posedge mclk);
    host_rd <= 1'b1;
    host_sel <= sel;
    @(posedge mclk);
    host_rd <= 1'b0;
    // Bounded wait for the answer pulse
    repeat (3) begin
      #1;
      if (host_rvalid !== 1'b1) @(posedge mclk);
    end
    check(host_rvalid, 1'b1);
    got = host_rdata;
  endtask : get
  // Nine reads so the ninth shows the pointer wrapping back to byte 0
  task automatic dump();
    put(SEL_COMMAND, CMD_READ_RAM);
    for (int k = 0; k < 9; k++) exp_q.push_back(exp_ram[8 * (k % 8) +: 8]);
    for (int k = 0; k < 9; k++) begin
      get(SEL_DATA);
      check(got, exp_q.pop_front());
    end
  endtask : dump
  task automatic judge(input logic [63:0] old);
    logic want_irq;
    repeat (3) @(posedge mclk);
    #1;
    exp_ram = {29'h0, emit_on ? col_block : COL_ALL_DARK, 2'h0,
      emit_on ? row_block : ROW_ALL_DARK};
    want_irq = (old !== exp_ram);
    check(panel_irq_request, want_irq);
    check(irq_request_reg, {other_irq[7:5], want_irq, other_irq[3:0]});
    check(emitter_disable_n, emit_on);
    get(SEL_EMITTER);
    check(got, {7'h0, emit_on});
    dump();
    // Host waits after the clear before checking that the interrupt has dropped
    put(SEL_COMMAND, CMD_CLEAR_IRQ);
    repeat (3) @(posedge mclk);
    #1;
    check(panel_irq_request, 1'b0);
    check(irq_request_reg[4], 1'b0);
  endtask : judge
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      give_verdict();
    end
  end
  initial begin
    emit_on = 1'b1;
    exp_ram = RAM_RST;
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    judge(exp_ram);
    put(SEL_EMITTER, EMIT_OFF);
    emit_on = 1'b0;
    judge(exp_ram);
    // Undefined emitter values must leave the latch alone
    put(SEL_EMITTER, 8'h05);
    judge(exp_ram);
    put(SEL_EMITTER, EMIT_ON);
    emit_on = 1'b1;
    judge(exp_ram);
    for (int i = 0; i < 12; i++) begin
      @(posedge mclk);
      rnd = lfsr(rnd);
      row_block <= {rnd[5:0], rnd};
      rnd = lfsr(rnd);
      col_block <= rnd[10:0];
      other_irq <= rnd[15:8];
      judge(exp_ram);
    end
    give_verdict();
  end
endmodule : irb_bezel_scan_tb_top
`default_nettype wire
